// ===== dv/ssp_peer.sv
/*
 * far-side peripheral for the serial port: a select-framed slave, clock idle
 * low, sampling on the rising clock edge and shifting on the falling one.
 * assumes its pins are sampled on clk and the clock half period is >= 2 clk.
 */
`timescale 1ns/10ps
module ssp_peer (
	input  wire logic        clk,
	input  wire logic        sclk,
	input  wire logic        sel_n,
	input  wire logic        mosi,
	input  wire logic [15:0] tx_word,
	input  wire logic [3:0]  size_m1,
	output logic             miso,
	output logic [15:0]      rx_word
);
	logic       sclk_q = 1'b0;
	logic       sel_q  = 1'b1;
	logic       last_q = 1'b0;
	logic [3:0] idx_q  = 4'h0;

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk) begin
		sclk_q <= sclk;
		sel_q  <= sel_n;
		if (!sel_n) begin
			last_q <= miso;
		end
		if (sel_q && !sel_n) begin
			idx_q   <= size_m1;
			rx_word <= 16'h0000;
		end else if (!sel_n && sclk && !sclk_q) begin
			rx_word <= {rx_word[14:0], mosi};
		end else if (!sel_n && !sclk && sclk_q && idx_q != 4'h0) begin
			idx_q <= idx_q - 4'h1;
		end
	end

	// a released line shows the inverse of its last value
	assign miso = sel_n ? ~last_q : tx_word[idx_q];
endmodule // ssp_peer

// ===== dv/testbench.sv
/*
 * self-checking bench for the serial port: loopback in every format and clock
 * mode, exchange with a peer slave, fifo fill and overrun, slave frames.
 * assumes ssp_peer as the far side while the port is master.
 */
`timescale 1ns/10ps
module testbench
	import ssp_pkg::*;
;
	logic         mclk, rst_n, tx_valid, tx_ready, rx_valid, rx_ready, busy;
	logic         m_sclk, m_frm, m_mosi, peer_miso, s;
	logic [15:0]  tx_data, rx_data, peer_tx, peer_rx, lfsr_q, got, w;
	logic [15:0]  ws [8];
	logic [3:0]   sz;
	logic [7:0]   p, d;
	ssp_cfg_type  cfg;
	ssp_link_type li, lo, loe;
	int           failures, total_checks, cycles, n;

	assign li = {loe.sclk ? lo.sclk : m_sclk, loe.frm ? lo.frm : m_frm,
		cfg.master ? peer_miso : m_mosi};

	ssp_port dut_u (.MCLK(mclk), .RST_N(rst_n), .CFG(cfg), .TX_VALID(tx_valid),
		.TX_DATA(tx_data), .TX_READY(tx_ready), .RX_VALID(rx_valid), .RX_DATA(rx_data),
		.RX_READY(rx_ready), .LINK_I(li), .LINK_O(lo), .LINK_OE(loe), .BUSY(busy));

	ssp_peer peer_u (.clk(mclk), .sclk(lo.sclk), .sel_n(lo.frm), .mosi(lo.data),
		.tx_word(peer_tx), .size_m1(cfg.size_m1), .miso(peer_miso), .rx_word(peer_rx));

	////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] mask(input logic [15:0] v, input int bits);
		return v & ((16'h0001 << bits) - 16'h0001);
	endfunction

	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction

	task automatic next_rnd();
		lfsr_q = lfsr_next(lfsr_q);
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		if (failures == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic push(input logic [15:0] v);
		tx_valid <= 1'b1;
		tx_data  <= v;
		@(posedge mclk);
		while (tx_ready !== 1'b1) @(posedge mclk);
		tx_valid <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic pop(output logic [15:0] v);
		rx_ready <= 1'b1;
		@(posedge mclk);
		while (rx_valid !== 1'b1) @(posedge mclk);
		v = rx_data;
		rx_ready <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wait_quiet();
		int k;
		k = 0;
		while (k < 10) begin
			@(posedge mclk);
			k = (busy === 1'b0) ? k + 1 : 0;
		end
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	always @(posedge mclk) begin
		cycles++;
		if (cycles == 60000) begin
			failures++;
			print_verdict();
		end
	end

	initial begin
		rst_n = 1'b0;
		tx_valid = 1'b0;
		rx_ready = 1'b0;
		tx_data = 16'h0000;
		peer_tx = 16'h0000;
		m_sclk = 1'b0;
		m_frm = 1'b1;
		m_mosi = 1'b0;
		cfg = '0;
		lfsr_q = 16'h004b;
		failures = 0;
		total_checks = 0;
		cycles = 0;
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		@(posedge mclk);
		// loopback: four spi clock modes, sync pulse, command
		for (int i = 0; i < 6; i++) begin
			next_rnd();
			sz = 4'h3 + 4'(lfsr_q[3:0] % 13);
			p = {6'h00, lfsr_q[5:4]};
			d = {7'h00, lfsr_q[6]};
			cfg <= '{enable: 1'b1, master: 1'b1, fmt: (i < 4) ? 2'b00 : 2'(i - 3),
				size_m1: sz, cpol: i[0], cpha: i[1], loopback: 1'b1,
				slave_tx_off: 1'b0, prescale: p, divider: d};
			@(posedge mclk);
			next_rnd();
			w = lfsr_q;
			push(w);
			if (i < 4) begin
				s = lo.sclk;
				while (lo.sclk === s) @(posedge mclk);
				n = 0;
				s = lo.sclk;
				while (lo.sclk === s) begin
					@(posedge mclk);
					n++;
				end
				check(16'(n), 16'((p + 1) * (d + 1)));
			end
			pop(got);
			check(got, (i == 5) ? 16'h0000 : mask(w, sz + 1));
			wait_quiet();
			repeat (5) begin
				@(posedge mclk);
				check(16'(lo.sclk), 16'((i < 4) ? i[0] : 1'b0));
			end
		end
		// exchange with the peer, shortest and longest frames first
		for (int k = 0; k < 4; k++) begin
			next_rnd();
			sz = (k == 0) ? 4'h3 : (k == 1) ? 4'hf : 4'h3 + 4'(lfsr_q[3:0] % 13);
			cfg <= '{enable: 1'b1, master: 1'b1, fmt: 2'b00, size_m1: sz, cpol: 1'b0,
				cpha: 1'b0, loopback: 1'b0, slave_tx_off: 1'b0,
				prescale: 8'h01, divider: 8'h01};
			peer_tx <= ~lfsr_q;
			@(posedge mclk);
			check(16'(loe), 16'h0007);
			push(lfsr_q);
			@(posedge mclk);
			check(16'(busy), 16'h0001);
			pop(got);
			check(got, mask(~lfsr_q, sz + 1));
			check(peer_rx, mask(lfsr_q, sz + 1));
			wait_quiet();
		end
		// fill the transmit fifo while off, then overrun the receive fifo
		cfg.enable <= 1'b0;
		cfg.loopback <= 1'b1;
		@(posedge mclk);
		for (int k = 0; k < 8; k++) begin
			next_rnd();
			ws[k] = lfsr_q;
			push(lfsr_q);
		end
		@(posedge mclk);
		check(16'(tx_ready), 16'h0000);
		cfg.enable <= 1'b1;
		wait_quiet();
		push(16'h5a5a);
		wait_quiet();
		for (int k = 0; k < 8; k++) begin
			pop(got);
			check(got, mask(ws[k], sz + 1));
		end
		check(16'(rx_valid), 16'h0000);
		// slave frames, data line driven and then released
		for (int k = 0; k < 2; k++) begin
			next_rnd();
			cfg <= '{enable: 1'b1, master: 1'b0, fmt: 2'b00, size_m1: 4'h7, cpol: 1'b0,
				cpha: 1'b0, loopback: 1'b0, slave_tx_off: k[0],
				prescale: 8'h00, divider: 8'h00};
			repeat (2) @(posedge mclk);
			check(16'(loe), 16'h0000);
			m_frm <= 1'b0;
			for (int b = 7; b >= 0; b--) begin
				m_mosi <= lfsr_q[b];
				repeat (4) @(posedge mclk);
				m_sclk <= 1'b1;
				repeat (4) @(posedge mclk);
				if (b == 4) check(16'(loe.data), 16'(!k[0]));
				m_sclk <= 1'b0;
			end
			repeat (4) @(posedge mclk);
			m_frm <= 1'b1;
			m_mosi <= ~lfsr_q[0];
			pop(got);
			check(got, {8'h00, lfsr_q[7:0]});
		end
		print_verdict();
	end
endmodule // testbench

// ===== rtl/ssp_pkg.sv
/*
 * constants and types shared by the synchronous serial port.
 * assumes a single clock domain; the link pins are sampled as synchronous inputs.
 */
package ssp_pkg;

	localparam int DATA_W     = 16;
	localparam int FIFO_DEPTH = 8;
	localparam int EDGE_W     = 5;

	// frame size is held as bits minus one; 4 to 16 bits
	localparam logic [3:0] SIZE_M1_MIN = 4'h3;
	localparam logic [3:0] WORD_MSB    = 4'hf;
	// last edge index of the lead-in period and of the command byte
	localparam logic [EDGE_W-1:0] PRE_LAST = 5'h01;
	localparam logic [EDGE_W-1:0] CMD_LAST = 5'h0f;
	localparam logic [7:0] CMD_PAD     = 8'h00;
	localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
	// idle levels of the frame line and the fixed-format clock: select is active low, sync pulse active high
	localparam logic SEL_IDLE  = 1'b1;
	localparam logic SYNC_IDLE = 1'b0;
	localparam logic SCLK_IDLE_FIXED = 1'b0;

	typedef enum logic [1:0] {
		FMT_SPI  = 2'b00,
		FMT_SYNC = 2'b01,
		FMT_CMD  = 2'b10
	} ssp_fmt_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_PRE  = 3'b001,
		ST_CMD  = 3'b010,
		ST_DATA = 3'b011,
		ST_END  = 3'b100
	} ssp_state_type;

	typedef struct packed {
		logic        enable;
		logic        master;
		logic [1:0]  fmt;
		logic [3:0]  size_m1;
		logic        cpol;
		logic        cpha;
		logic        loopback;
		logic        slave_tx_off;
		logic [7:0]  prescale;
		logic [7:0]  divider;
	} ssp_cfg_type;

	typedef struct packed {
		logic sclk;
		logic frm;
		logic data;
	} ssp_link_type;

endpackage

// ===== rtl/ssp_port.sv
/*
 * synchronous serial port: word fifos in both directions, a serial engine for
 * three frame formats, master clock generation and slave operation.
 * assumes link inputs are synchronous to MCLK and the configuration is only
 * changed while the port is idle.
 */
//
// Behaviour
// - the link has four wires: transmit data, receive data, serial clock and frame.
// - three frame formats are selectable: select-framed spi, sync pulse, and command.
// - the frame carries 4 to 16 bits as configured, both ends agreeing.
// - received bits are shifted into words and fifo words are shifted out serially.
// - transmit and receive each have their own eight-entry fifo of 16-bit words.
// - the port is master, driving clock and frame, or slave, taking them from outside.
// - a slave can be told to leave its transmit line undriven.
// - as master the bit clock comes from MCLK through a prescaler and then a divider.
// - loopback feeds the transmit line straight back to the receiver.
`timescale 1ns/10ps
module ssp_port
	import ssp_pkg::*;
#(
	parameter int DEPTH = FIFO_DEPTH
) (
	input  wire logic                MCLK,
	input  wire logic                RST_N,
	input  wire ssp_cfg_type         CFG,
	input  wire logic                TX_VALID,
	input  wire logic [DATA_W-1:0]   TX_DATA,
	output logic                     TX_READY,
	output logic                     RX_VALID,
	output logic [DATA_W-1:0]        RX_DATA,
	input  wire logic                RX_READY,
	input  wire ssp_link_type        LINK_I,
	output ssp_link_type             LINK_O,
	output ssp_link_type             LINK_OE,
	output logic                     BUSY
);

	localparam int PTR_W = $clog2(DEPTH);

	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_depth_chk
		$error("fifo depth must be a power of two of at least two");
	end

	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!RST_N);

	////////////////////////////////////////////////////////////////////////////////
	// state
	ssp_state_type             state_q, state_d;
	logic [EDGE_W-1:0]         edge_q, edge_d;
	logic [DATA_W-1:0]         tx_sr_q, tx_sr_d, rx_sr_q, rx_sr_d, hold_q, hold_d;
	logic [7:0]                pre_q, pre_d, div_q, div_d;
	logic                      sclk_prev_q, frm_prev_q;
	ssp_link_type              out_q, out_d, oe_q, oe_d;
	logic                      busy_q;
	logic [DATA_W-1:0]         tx_mem_q [DEPTH];
	logic [DATA_W-1:0]         tx_mem_d [DEPTH];
	logic [DATA_W-1:0]         rx_mem_q [DEPTH];
	logic [DATA_W-1:0]         rx_mem_d [DEPTH];
	logic [PTR_W-1:0]          tx_wr_q, tx_wr_d, tx_rd_q, tx_rd_d;
	logic [PTR_W-1:0]          rx_wr_q, rx_wr_d, rx_rd_q, rx_rd_d;
	logic [PTR_W:0]            tx_cnt_q, tx_cnt_d, rx_cnt_q, rx_cnt_d;
	logic                      tx_ready_q, rx_valid_q;
	logic [DATA_W-1:0]         rx_data_q;

	////////////////////////////////////////////////////////////////////////////////
	// format decode
	ssp_fmt_type               fmt;
	logic [3:0]                size_m1;
	logic                      cpha_eff, cpol_eff, frm_idle, lead, sample_ev, shift_ev;
	logic                      half_tick, pin_edge, tick, rx_line, in_frame, slave_start;
	logic                      pop_tx, push_rx, last;
	logic [EDGE_W-1:0]         last_edge;
	logic [DATA_W-1:0]         tx_word;

	always_comb begin
		unique case (CFG.fmt)
			2'b01:   fmt = FMT_SYNC;
			2'b10:   fmt = FMT_CMD;
			default: fmt = FMT_SPI;
		endcase
	end

	assign size_m1  = (CFG.size_m1 < SIZE_M1_MIN) ? SIZE_M1_MIN : CFG.size_m1;
	assign cpha_eff = (fmt == FMT_SPI) ? CFG.cpha : (fmt == FMT_SYNC);
	assign cpol_eff = (fmt == FMT_SPI) ? CFG.cpol : SCLK_IDLE_FIXED;
	assign frm_idle = (fmt == FMT_SYNC) ? SYNC_IDLE : SEL_IDLE;
	assign in_frame = (state_q == ST_CMD) || (state_q == ST_DATA);
	assign lead     = ~edge_q[0];

	////////////////////////////////////////////////////////////////////////////////
	// bit clock: half period is (prescale+1)*(divider+1) MCLK cycles
	always_comb begin
		pre_d = pre_q;
		div_d = div_q;
		if (state_q == ST_IDLE) begin
			pre_d = CFG.prescale;
			div_d = CFG.divider;
		end else if (pre_q != 8'h00) begin
			pre_d = pre_q - 8'h01;
		end else begin
			pre_d = CFG.prescale;
			div_d = (div_q == 8'h00) ? CFG.divider : div_q - 8'h01;
		end
	end

	assign half_tick   = (state_q != ST_IDLE) && pre_q == 8'h00 && div_q == 8'h00;
	assign pin_edge    = (LINK_I.sclk != sclk_prev_q) && (state_q != ST_IDLE);
	assign tick        = CFG.master ? half_tick : pin_edge;
	assign rx_line     = CFG.loopback ? out_q.data : LINK_I.data;
	assign sample_ev   = tick && in_frame && (lead ^ cpha_eff);
	assign shift_ev    = tick && in_frame && !(lead ^ cpha_eff) && edge_q != '0;
	assign slave_start = (fmt == FMT_SYNC) ? (sclk_prev_q && !LINK_I.sclk && LINK_I.frm)
	                                       : (frm_prev_q && !LINK_I.frm);
	assign tx_word     = (tx_cnt_q != '0) ? tx_mem_q[tx_rd_q] << (WORD_MSB - size_m1)
	                                      : WORD_ZERO;

	always_comb begin
		unique case (state_q)
			ST_PRE:  last_edge = PRE_LAST;
			ST_CMD:  last_edge = CMD_LAST;
			default: last_edge = {size_m1, 1'b1};
		endcase
	end
	assign last = tick && edge_q == last_edge;

	////////////////////////////////////////////////////////////////////////////////
	// serial engine
	always_comb begin
		state_d = state_q;
		edge_d  = edge_q;
		tx_sr_d = tx_sr_q;
		rx_sr_d = rx_sr_q;
		hold_d  = hold_q;
		out_d   = out_q;
		pop_tx  = 1'b0;
		push_rx = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				out_d.sclk = cpol_eff;
				out_d.frm  = frm_idle;
				edge_d     = '0;
				rx_sr_d    = WORD_ZERO;
				if (CFG.enable && CFG.master && tx_cnt_q != '0) begin
					pop_tx  = 1'b1;
					hold_d  = tx_word;
					tx_sr_d = (fmt == FMT_CMD) ? {tx_mem_q[tx_rd_q][7:0], CMD_PAD} : tx_word;
					out_d.frm = ~frm_idle;
					state_d = (fmt == FMT_SYNC) ? ST_PRE :
					          (fmt == FMT_CMD) ? ST_CMD : ST_DATA;
				end else if (CFG.enable && !CFG.master && slave_start) begin
					pop_tx  = tx_cnt_q != '0;
					hold_d  = tx_word;
					tx_sr_d = (fmt == FMT_CMD) ? WORD_ZERO : tx_word;
					state_d = (fmt == FMT_CMD) ? ST_CMD : ST_DATA;
				end
			end
			ST_PRE, ST_CMD, ST_DATA: begin
				if (tick) begin
					edge_d = edge_q + 5'h01;
					if (CFG.master) begin
						out_d.sclk = ~out_q.sclk;
					end
				end
				if (sample_ev) begin
					rx_sr_d = {rx_sr_q[DATA_W-2:0], rx_line};
				end
				if (shift_ev) begin
					tx_sr_d = {tx_sr_q[DATA_W-2:0], 1'b0};
				end
				if (last) begin
					edge_d  = '0;
					state_d = ST_DATA;
					if (state_q == ST_PRE) begin
						out_d.frm = SYNC_IDLE;
					end else if (state_q == ST_CMD) begin
						rx_sr_d = WORD_ZERO;
						tx_sr_d = CFG.master ? WORD_ZERO : hold_q;
					end else begin
						push_rx = 1'b1;
						state_d = CFG.master ? ST_END : ST_IDLE;
					end
				end
				if (!CFG.master && fmt != FMT_SYNC && LINK_I.frm) begin
					state_d = ST_IDLE;
				end
			end
			ST_END: begin
				out_d.frm = frm_idle;
				if (tick) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
		out_d.data   = tx_sr_d[DATA_W-1];
		oe_d.sclk    = CFG.enable && CFG.master;
		oe_d.frm     = CFG.enable && CFG.master;
		oe_d.data    = CFG.enable && (CFG.master ||
		               (state_d != ST_IDLE && !CFG.slave_tx_off));
	end

	////////////////////////////////////////////////////////////////////////////////
	// fifos
	always_comb begin
		tx_mem_d = tx_mem_q;
		rx_mem_d = rx_mem_q;
		tx_wr_d  = tx_wr_q;
		tx_rd_d  = tx_rd_q;
		rx_wr_d  = rx_wr_q;
		rx_rd_d  = rx_rd_q;
		tx_cnt_d = tx_cnt_q;
		rx_cnt_d = rx_cnt_q;
		if (TX_VALID && tx_ready_q) begin
			tx_mem_d[tx_wr_q] = TX_DATA;
			tx_wr_d  = tx_wr_q + 1'b1;
			tx_cnt_d = tx_cnt_d + 1'b1;
		end
		if (pop_tx) begin
			tx_rd_d  = tx_rd_q + 1'b1;
			tx_cnt_d = tx_cnt_d - 1'b1;
		end
		if (push_rx && rx_cnt_q != (PTR_W+1)'(DEPTH)) begin
			rx_mem_d[rx_wr_q] = rx_sr_d;
			rx_wr_d  = rx_wr_q + 1'b1;
			rx_cnt_d = rx_cnt_d + 1'b1;
		end
		if (RX_READY && rx_valid_q) begin
			rx_rd_d  = rx_rd_q + 1'b1;
			rx_cnt_d = rx_cnt_d - 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			state_q     <= ST_IDLE;
			edge_q      <= '0;
			tx_sr_q     <= WORD_ZERO;
			rx_sr_q     <= WORD_ZERO;
			hold_q      <= WORD_ZERO;
			pre_q       <= 8'h00;
			div_q       <= 8'h00;
			sclk_prev_q <= 1'b0;
			frm_prev_q  <= SEL_IDLE;
			out_q       <= '{sclk: 1'b0, frm: SEL_IDLE, data: 1'b0};
			oe_q        <= '0;
			busy_q      <= 1'b0;
			tx_mem_q    <= '{default: WORD_ZERO};
			rx_mem_q    <= '{default: WORD_ZERO};
			tx_wr_q     <= '0;
			tx_rd_q     <= '0;
			rx_wr_q     <= '0;
			rx_rd_q     <= '0;
			tx_cnt_q    <= '0;
			rx_cnt_q    <= '0;
			tx_ready_q  <= 1'b0;
			rx_valid_q  <= 1'b0;
			rx_data_q   <= WORD_ZERO;
		end else begin
			state_q     <= state_d;
			edge_q      <= edge_d;
			tx_sr_q     <= tx_sr_d;
			rx_sr_q     <= rx_sr_d;
			hold_q      <= hold_d;
			pre_q       <= pre_d;
			div_q       <= div_d;
			sclk_prev_q <= LINK_I.sclk;
			frm_prev_q  <= LINK_I.frm;
			out_q       <= out_d;
			oe_q        <= oe_d;
			busy_q      <= state_d != ST_IDLE;
			tx_mem_q    <= tx_mem_d;
			rx_mem_q    <= rx_mem_d;
			tx_wr_q     <= tx_wr_d;
			tx_rd_q     <= tx_rd_d;
			rx_wr_q     <= rx_wr_d;
			rx_rd_q     <= rx_rd_d;
			tx_cnt_q    <= tx_cnt_d;
			rx_cnt_q    <= rx_cnt_d;
			tx_ready_q  <= tx_cnt_d != (PTR_W+1)'(DEPTH);
			rx_valid_q  <= rx_cnt_d != '0;
			rx_data_q   <= rx_mem_d[rx_rd_d];
		end
	end

	assign TX_READY = tx_ready_q;
	assign RX_VALID = rx_valid_q;
	assign RX_DATA  = rx_data_q;
	assign LINK_O   = out_q;
	assign LINK_OE  = oe_q;
	assign BUSY     = busy_q;

	////////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_master_go;
		state_q == ST_IDLE && CFG.enable && CFG.master && tx_cnt_q != '0;
	endsequence
	sequence s_frame_open;
		state_q != ST_IDLE && oe_q.sclk;
	endsequence

	master_start_a: assert property (s_master_go |=> s_frame_open)
		else $error("master did not open a frame with data waiting");
	idle_clock_a: assert property (CFG.master && state_q == ST_IDLE && tx_cnt_q == '0
		|=> out_q.sclk == $past(cpol_eff) && state_q == ST_IDLE)
		else $error("master clock moved or frame began with empty fifo");
	slave_quiet_a: assert property (!CFG.master && CFG.slave_tx_off |=> !oe_q.data)
		else $error("slave drove its data line while told not to");
	fifo_bound_a: assert property (tx_cnt_q <= DEPTH && rx_cnt_q <= DEPTH)
		else $error("fifo count beyond depth");
	rx_justify_a: assert property (push_rx |-> (rx_sr_d >> ({1'b0, size_m1} + 5'h01)) == WORD_ZERO)
		else $error("received word not right-justified");
	loop_route_a: assert property (CFG.loopback && sample_ev |=> rx_sr_q[0] == $past(out_q.data))
		else $error("loopback sample did not come from transmit line");
	frame_len_a: assert property (state_q == ST_DATA |-> edge_q <= {size_m1, 1'b1})
		else $error("frame ran past its size");
	tick_source_a: assert property (CFG.master && tick |-> pre_q == 8'h00 && div_q == 8'h00)
		else $error("bit clock edge not from prescaler and divider");
	shift_out_a: assert property (shift_ev && !last |=> tx_sr_q == {$past(tx_sr_q[DATA_W-2:0]), 1'b0})
		else $error("transmit word did not shift");
	line_follow_a: assert property (##1 out_q.data == $past(tx_sr_d[DATA_W-1]))
		else $error("transmit line not following the shift register");
	sync_pulse_a: assert property (CFG.master && fmt == FMT_SYNC && state_q == ST_PRE
		|-> out_q.frm != SYNC_IDLE)
		else $error("sync pulse missing during lead-in");

endmodule // ssp_port
